// File: rtl/arf_pkg.sv
/*
 * arf_pkg: register offsets, field positions, reset values and code constants
 * of the converter result formatting block.
 * assumes: 32-bit AXI4-Lite register bus, 10-bit converter codes.
 */
package arf_pkg;
   // widths
   localparam int CODE_W = 10;
   localparam int BYTE_W = 8;
   // byte offsets of the registers
   localparam logic [3:0] CTRL_OFS = 4'h0;
   localparam logic [3:0] STAT_OFS = 4'h4;
   localparam logic [3:0] RLOW_OFS = 4'h8;
   localparam logic [3:0] RHIGH_OFS = 4'hC;
   // control register fields
   localparam int CTRL_ALIGN_BIT = 0;
   localparam int CTRL_SHORT_BIT = 1;
   localparam int CTRL_DIFF_BIT = 2;
   localparam logic [2:0] CTRL_RST = 3'h0;
   // status register fields
   localparam int STAT_DONE_BIT = 0;
   localparam logic STAT_DONE_RST = 1'b0;
   localparam logic [9:0] CODE_RST = 10'h000;
   // code range markers
   localparam logic [9:0] SE_MIN = 10'h000;
   localparam logic [9:0] SE_MAX = 10'h3FF;
   localparam logic [9:0] DIFF_MIN = 10'h200;
   localparam logic [9:0] DIFF_MAX = 10'h1FF;
   // bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: rtl/arf_fmt_if.sv
/*
 * arf_fmt_if: carries the stored code and alignment choice to the formatter
 * and the two result bytes back.
 * assumes: one clock domain, purely combinational formatter.
 */
`timescale 1ns/1ps
interface arf_fmt_if;
   logic [9:0] code;
   logic leftAlign;
   logic [7:0] resLow;
   logic [7:0] resHigh;
   modport fmt (input code, input leftAlign, output resLow, output resHigh);
   modport user (output code, output leftAlign, input resLow, input resHigh);
endinterface

// File: rtl/arf_align.sv
/*
 * arf_align: splits a 10-bit result across the low/high register pair,
 * left or right aligned.
 * assumes: inputs come from flip-flops of the same clock.
 */
`timescale 1ns/1ps
module arf_align
(
   // formatter side
   arf_fmt_if.fmt port
);
   // alignment follows the select bit at once, no conversion needed
   assign port.resHigh = port.leftAlign ? port.code[9:2] : {6'h00, port.code[9:8]};
   assign port.resLow = port.leftAlign ? {port.code[1:0], 6'h00} : port.code[7:0];
endmodule

// File: rtl/arf_result_fmt.sv
/*
 * arf_result_fmt: result path of a 10-bit converter with an AXI4-Lite
 * register slave (control, status, result low, result high).
 * assumes: convValid/convRaw come from converter logic on ref_clk;
 * convRaw is offset binary (0x000 lowest input, 0x3FF highest).
 */
// Notes on behaviour
// - result low/high registers hold the finished result once done flag is high
// - single-ended result is unsigned code, 0x000 ground, 0x3FF reference
// - differential result is two's complement, 0x200 most negative, 0x1FF most positive
// - result MSB sits in the high register; one means negative for differential
// - short control bit ties both amplifier inputs together for offset measurement
// - done flag sets as the result registers take the new value
// - alignment bit change reformats result registers immediately, even mid-conversion
`timescale 1ns/1ps
module arf_result_fmt
(
   // clock, reset, enable
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic ce,
   // converter core
   input wire logic convValid,
   input wire logic [9:0] convRaw,
   output logic ampInputShort,
   // axi4-lite write address
   input wire logic [3:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   // axi4-lite write data
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   // axi4-lite write response
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // axi4-lite read address
   input wire logic [3:0] araddr,
   input wire logic arvalid,
   output logic arready,
   // axi4-lite read data
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready
);
   ////////////////////////////////////////////////////////////////////////////
   logic [2:0] ctrl_reg, ctrl_next;
   logic conv_done_flag_reg, conv_done_flag_next;
   logic [9:0] code_reg, code_next;
   logic awHeld_reg, awHeld_next, wHeld_reg, wHeld_next;
   logic [3:0] awAddr_reg, awAddr_next;
   logic [7:0] wByte_reg, wByte_next;
   logic wLane_reg, wLane_next;
   logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
   logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
   logic [31:0] rdata_reg, rdata_next;
   logic awFire, wFire, arFire, doWrite, wrLane;
   logic [3:0] wrAddr;
   logic [7:0] wrByte;
   logic convFire, doneClear, ctrlWrite;
   logic [9:0] fmtCode;
   logic [7:0] rdByte;
   arf_fmt_if fmtBus ();

   ////////////////////////////////////////////////////////////////////////////
   // address check, shared by both paths
   function automatic logic isMapped(input logic [3:0] a);
      isMapped = (a == arf_pkg::CTRL_OFS) || (a == arf_pkg::STAT_OFS) ||
                 (a == arf_pkg::RLOW_OFS) || (a == arf_pkg::RHIGH_OFS);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // write channel handshakes; address and data may come in either order
   assign awready = !awHeld_reg && !bvalid_reg;
   assign wready = !wHeld_reg && !bvalid_reg;
   assign awFire = awvalid && awready;
   assign wFire = wvalid && wready;
   assign wrAddr = awHeld_reg ? awAddr_reg : awaddr;
   assign wrByte = wHeld_reg ? wByte_reg : wdata[7:0];
   assign wrLane = wHeld_reg ? wLane_reg : wstrb[0];
   assign doWrite = (awHeld_reg || awFire) && (wHeld_reg || wFire);
   assign ctrlWrite = doWrite && wrLane && (wrAddr == arf_pkg::CTRL_OFS);
   assign doneClear = doWrite && wrLane && (wrAddr == arf_pkg::STAT_OFS) &&
                      wrByte[arf_pkg::STAT_DONE_BIT];
   assign awHeld_next = doWrite ? 1'b0 : (awHeld_reg || awFire);
   assign wHeld_next = doWrite ? 1'b0 : (wHeld_reg || wFire);
   assign awAddr_next = awFire ? awaddr : awAddr_reg;
   assign wByte_next = wFire ? wdata[7:0] : wByte_reg;
   assign wLane_next = wFire ? wstrb[0] : wLane_reg;
   assign bvalid_next = doWrite || (bvalid_reg && !bready);
   assign bresp_next = doWrite ? (isMapped(wrAddr) ? arf_pkg::RESP_OKAY : arf_pkg::RESP_SLVERR) : bresp_reg;
   assign bvalid = bvalid_reg;
   assign bresp = bresp_reg;

   ////////////////////////////////////////////////////////////////////////////
   // read channel: one outstanding read, data registered at the address edge
   assign arready = !rvalid_reg;
   assign arFire = arvalid && arready;
   assign rdByte = (araddr == arf_pkg::CTRL_OFS) ? {5'h00, ctrl_reg} :
                   (araddr == arf_pkg::STAT_OFS) ? {7'h00, conv_done_flag_reg} :
                   (araddr == arf_pkg::RLOW_OFS) ? fmtBus.resLow :
                   (araddr == arf_pkg::RHIGH_OFS) ? fmtBus.resHigh : 8'h00;
   assign rdata_next = arFire ? {24'h000000, rdByte} : rdata_reg;
   assign rresp_next = arFire ? (isMapped(araddr) ? arf_pkg::RESP_OKAY : arf_pkg::RESP_SLVERR) : rresp_reg;
   assign rvalid_next = arFire || (rvalid_reg && !rready);
   assign rvalid = rvalid_reg;
   assign rdata = rdata_reg;
   assign rresp = rresp_reg;

   ////////////////////////////////////////////////////////////////////////////
   // result capture: code conversion and done flag in the same edge
   assign convFire = convValid;
   assign fmtCode = ctrl_reg[arf_pkg::CTRL_DIFF_BIT] ? {~convRaw[9], convRaw[8:0]}
                                                     : convRaw;
   assign code_next = convFire ? fmtCode : code_reg;
   // a new result wins over a clear in the same cycle
   assign conv_done_flag_next = convFire || (conv_done_flag_reg && !doneClear);
   assign ctrl_next = ctrlWrite ? wrByte[2:0] : ctrl_reg;
   assign ampInputShort = ctrl_reg[arf_pkg::CTRL_SHORT_BIT];

   ////////////////////////////////////////////////////////////////////////////
   // formatter: alignment read live from the control register
   assign fmtBus.code = code_reg;
   assign fmtBus.leftAlign = ctrl_reg[arf_pkg::CTRL_ALIGN_BIT];
   arf_align u_arf_align
   (
      .port(fmtBus.fmt)
   );

   ////////////////////////////////////////////////////////////////////////////
   // state registers, frozen while ce is low
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         ctrl_reg <= arf_pkg::CTRL_RST;
         conv_done_flag_reg <= arf_pkg::STAT_DONE_RST;
         code_reg <= arf_pkg::CODE_RST;
         awHeld_reg <= 1'b0;
         wHeld_reg <= 1'b0;
         awAddr_reg <= 4'h0;
         wByte_reg <= 8'h00;
         wLane_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= arf_pkg::RESP_OKAY;
         rvalid_reg <= 1'b0;
         rresp_reg <= arf_pkg::RESP_OKAY;
         rdata_reg <= 32'h00000000;
      end
      else if (ce)
      begin
         ctrl_reg <= ctrl_next;
         conv_done_flag_reg <= conv_done_flag_next;
         code_reg <= code_next;
         awHeld_reg <= awHeld_next;
         wHeld_reg <= wHeld_next;
         awAddr_reg <= awAddr_next;
         wByte_reg <= wByte_next;
         wLane_reg <= wLane_next;
         bvalid_reg <= bvalid_next;
         bresp_reg <= bresp_next;
         rvalid_reg <= rvalid_next;
         rresp_reg <= rresp_next;
         rdata_reg <= rdata_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking chk @(posedge ref_clk);
   endclocking
   default disable iff (!nrst);

   done_on_result_a: assert property (ce && convValid |=> conv_done_flag_reg)
      else $error("done flag not set after result");
   se_code_pass_a: assert property (ce && convValid && !ctrl_reg[arf_pkg::CTRL_DIFF_BIT]
      |=> code_reg == $past(convRaw))
      else $error("single-ended code altered");
   diff_code_a: assert property (ce && convValid && ctrl_reg[arf_pkg::CTRL_DIFF_BIT]
      |=> code_reg == ($past(convRaw) ^ 10'h200))
      else $error("differential code not two's complement");
   sign_in_high_a: assert property (fmtBus.leftAlign ? fmtBus.resHigh[7] == code_reg[9]
      : fmtBus.resHigh[1] == code_reg[9])
      else $error("sign bit missing from high register");
   left_align_a: assert property (fmtBus.leftAlign |-> {fmtBus.resHigh, fmtBus.resLow} == {code_reg, 6'h00})
      else $error("left aligned layout wrong");
   right_align_a: assert property (!fmtBus.leftAlign |-> {fmtBus.resHigh, fmtBus.resLow} == {6'h00, code_reg})
      else $error("right aligned layout wrong");
   short_write_a: assert property (ce && ctrlWrite && wrByte[arf_pkg::CTRL_SHORT_BIT]
      |=> ampInputShort)
      else $error("amplifier short not applied");
   high_read_a: assert property (ce && arFire && araddr == arf_pkg::RHIGH_OFS
      |=> rvalid && rdata[7:0] == $past(fmtBus.resHigh))
      else $error("high result read mismatch");
   flag_sticky_a: assert property (ce && conv_done_flag_reg && !doneClear |=> conv_done_flag_reg)
      else $error("done flag dropped without clear");

   // result holding, done flag and amplifier short clearing, and readback
   done_clear_a: assert property (ce && doneClear && !convValid |=> !conv_done_flag_reg)
      else $error("done flag not cleared");
   hold_result_a: assert property (ce && !convValid |=> $stable(code_reg))
      else $error("stored result changed without strobe");
   freeze_state_a: assert property (!ce
      |=> $stable(code_reg) && $stable(conv_done_flag_reg) && $stable(ctrl_reg))
      else $error("state moved while enable low");
   short_clear_a: assert property (ce && ctrlWrite && !wrByte[arf_pkg::CTRL_SHORT_BIT]
      |=> !ampInputShort)
      else $error("amplifier short not released");
   low_read_a: assert property (ce && arFire && araddr == arf_pkg::RLOW_OFS
      |=> rvalid && rdata[7:0] == $past(fmtBus.resLow))
      else $error("low result read mismatch");
   read_top_zero_a: assert property (rvalid |-> rdata[31:8] == 24'h000000)
      else $error("upper read bits not zero");
   unmapped_read_a: assert property (ce && arFire && !isMapped(araddr)
      |=> rresp == arf_pkg::RESP_SLVERR)
      else $error("unmapped read not refused");
endmodule

// File: verification/tb_arf_result_fmt.sv
/*
 * tb_arf_result_fmt: self-checking bench for the converter result formatting block.
 * assumes: arf_pkg and the rtl modules are compiled first; ce is dropped once to check freezing.
 */
`timescale 1ns/1ps
module tb_arf_result_fmt;
   logic ref_clk, nrst, ce, convValid, ampInputShort;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [9:0] convRaw;
   logic [3:0] awaddr, wstrb, araddr;
   logic [31:0] wdata, rdata;
   logic [1:0] bresp, rresp;
   int errors = 0;
   int checks = 0;
   // device under test
   arf_result_fmt u_arf_result_fmt (.ref_clk, .nrst, .ce, .convValid, .convRaw, .ampInputShort, .awaddr,
      .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
      .arready, .rdata, .rresp, .rvalid, .rready);
   // 50 MHz clock
   initial
   begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   ////////////////////////////////////////////////////////////////////////////////////////////////////////
   // comparison and closing report
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic finish_test;
      $display("checks=%0d errors=%0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // bounded wait ran out
   task automatic hang;
      errors++;
      finish_test();
   endtask
   ////////////////////////////////////////////////////////////////////////////////////////////////////////
   // bus write: handshakes sampled at the falling edge, released after the rising one
   task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er = arf_pkg::RESP_OKAY);
      logic awTake, wTake, bTake;
      int n;
      @(posedge ref_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 20; n++)
      begin
         @(negedge ref_clk);
         awTake = awvalid && awready;
         wTake = wvalid && wready;
         bTake = bvalid;
         if (bTake) check(bresp, er);
         @(posedge ref_clk);
         if (awTake) awvalid <= 1'b0;
         if (wTake) wvalid <= 1'b0;
         if (bTake) break;
      end
      bready <= 1'b0;
      if (n == 20) hang();
   endtask
   // bus read compared against an expected word
   task automatic rdchk(input logic [3:0] a, input logic [31:0] exp, input logic [1:0] er = arf_pkg::RESP_OKAY);
      logic arTake, rTake;
      int n;
      @(posedge ref_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 20; n++)
      begin
         @(negedge ref_clk);
         arTake = arvalid && arready;
         rTake = rvalid;
         if (rTake) check(rdata, exp);
         if (rTake) check(rresp, er);
         @(posedge ref_clk);
         if (arTake) arvalid <= 1'b0;
         if (rTake) break;
      end
      rready <= 1'b0;
      if (n == 20) hang();
   endtask
   // one-cycle result strobe; no converter pin is toggled while a result is pending
   // results arrive as from a quiet, sleep-mode conversion, no noise is modelled
   task automatic conv(input logic [9:0] raw);
      @(posedge ref_clk);
      convValid <= 1'b1;
      convRaw <= raw;
      @(posedge ref_clk);
      convValid <= 1'b0;
   endtask
   // expected byte pair for a code in either alignment
   task automatic res_chk(input logic [9:0] c, input logic left);
      rdchk(arf_pkg::RLOW_OFS, left ? {24'h000000, c[1:0], 6'h00} : {24'h000000, c[7:0]});
      rdchk(arf_pkg::RHIGH_OFS, left ? {24'h000000, c[9:2]} : {24'h000000, 6'h00, c[9:8]});
   endtask
   ////////////////////////////////////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic test_reset;
      @(negedge ref_clk);
      check({awready, wready, arready, bvalid, rvalid}, 5'h1C);
      rdchk(arf_pkg::CTRL_OFS, 32'h00000000);
      rdchk(arf_pkg::STAT_OFS, 32'h00000000);
      check(ampInputShort, 1'b0);
      $display("test reset done");
   endtask
   task automatic test_single;
      logic [9:0] tbl [2] = '{10'h000, 10'h3FF};
      foreach (tbl[i])
      begin
         conv(tbl[i]);
         rdchk(arf_pkg::STAT_OFS, 32'h00000001);
         res_chk(tbl[i], 1'b0);
      end
      wr(arf_pkg::CTRL_OFS, 32'h00000001);
      res_chk(10'h3FF, 1'b1);
      $display("test single-ended done");
   endtask
   // raw offset-binary in, two's complement expected
   task automatic test_diff;
      logic [9:0] raw [4] = '{10'h000, 10'h3FF, 10'h070, 10'h229};
      logic [9:0] exp [4] = '{10'h200, 10'h1FF, 10'h270, 10'h029};
      foreach (raw[i])
      begin
         wr(arf_pkg::CTRL_OFS, 32'h00000004);
         conv(raw[i]);
         res_chk(exp[i], 1'b0);
         wr(arf_pkg::CTRL_OFS, 32'h00000005);
         res_chk(exp[i], 1'b1);
      end
      $display("test differential done");
   endtask
   task automatic test_short;
      wr(arf_pkg::CTRL_OFS, 32'h00000002);
      @(negedge ref_clk);
      check(ampInputShort, 1'b1);
      wr(arf_pkg::CTRL_OFS, 32'h00000000);
      @(negedge ref_clk);
      check(ampInputShort, 1'b0);
      $display("test short done");
   endtask
   // unmapped offset: refused on both paths, control untouched
   task automatic test_unmapped;
      wr(4'h2, 32'h00000007, arf_pkg::RESP_SLVERR);
      rdchk(4'h2, 32'h00000000, arf_pkg::RESP_SLVERR);
      rdchk(arf_pkg::CTRL_OFS, 32'h00000000);
      $display("test unmapped done");
   endtask
   // flag clears on write one, result stays readable
   task automatic test_clear;
      conv(10'h155);
      wr(arf_pkg::STAT_OFS, 32'h00000001);
      rdchk(arf_pkg::STAT_OFS, 32'h00000000);
      res_chk(10'h155, 1'b0);
      // new result and clear on the same edge: the result wins
      fork
         wr(arf_pkg::STAT_OFS, 32'h00000001);
         conv(10'h0AA);
      join
      rdchk(arf_pkg::STAT_OFS, 32'h00000001);
      res_chk(10'h0AA, 1'b0);
      // strobe while enable is low is not taken
      @(posedge ref_clk);
      ce <= 1'b0;
      conv(10'h3AA);
      @(posedge ref_clk);
      ce <= 1'b1;
      res_chk(10'h0AA, 1'b0);
      $display("test clear done");
   endtask
   ////////////////////////////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial
   begin
      {nrst, ce, convValid, awvalid, wvalid, bready, arvalid, rready} = 8'h40;
      {convRaw, awaddr, araddr, wdata} = 50'h0;
      wstrb = 4'hF;
      repeat (2) @(posedge ref_clk);
      nrst <= 1'b1;
      test_reset();
      test_single();
      test_diff();
      test_short();
      test_unmapped();
      test_clear();
      finish_test();
   end
endmodule
